// [include/sdl_defs.svh]
// Purpose: Constants for the serial DAC load link.
// Assumes: Host clock 100 MHz.
// Notes:   Frame layout is given as frame lengths and field widths, counted from the top of the frame.
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SDL_FRAME_SHORT      16
`define SDL_FRAME_LONG       24
`define SDL_PAD_BITS_LONG    6
`define SDL_MODE_BITS        2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SDL_CLK_MHZ          100
`define SDL_SCLK_MAX_MHZ     30
`define SDL_SYNC_HIGH_NS     33
`define SDL_CLK_PERIOD_NS    10
`define SDL_SYNC_HIGH_CYC    ((`SDL_SYNC_HIGH_NS + `SDL_CLK_PERIOD_NS - 1) / `SDL_CLK_PERIOD_NS)
// Least half period of the link clock, rounded up to whole host cycles
`define SDL_SCLK_HALF_CYC    ((`SDL_CLK_MHZ + 2 * `SDL_SCLK_MAX_MHZ - 1) / (2 * `SDL_SCLK_MAX_MHZ))
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDL_RESET_MODE       2'h0

`endif

// [include/sdl_pkg.sv]
// Purpose: Shared types for the serial DAC load link.
// Assumes: Nothing beyond the header.
// Notes:   Mode codes sit in the two control bits of a frame.
package sdl_pkg;
  typedef enum logic [1:0] {
    SDL_MODE_NORMAL = 2'h0,
    SDL_MODE_PD_1K  = 2'h1,
    SDL_MODE_PD_100K = 2'h2,
    SDL_MODE_TRISTATE = 2'h3
  } sdl_mode_t;
endpackage

// [include/sdl_link_if.sv]
// Purpose: Three-wire link between the host and the DAC load logic.
// Assumes: All three wires driven by the host only.
// Notes:   Select is active low.
interface sdl_link_if;
  logic syncN;
  logic sclk;
  logic din;
  modport host (output syncN, output sclk, output din);
  modport dev  (input syncN, input sclk, input din);
endinterface

// [verilog/sdl_device.sv]
// Purpose: DAC side of the three-wire load link; shifts frames and applies code and mode.
// Assumes: Link clock sclk is the device's own clock; rst is the power-on reset.
// Notes:   Code and mode are held in the link domain; no host-clock logic here.
`include "sdl_defs.svh"

module sdl_device #(
  parameter int  DATA_BITS  = 16,
  parameter bit  MIDSCALE   = 1'b0
) (
  // Link
  sdl_link_if.dev                link,
  // Reset
  input  wire logic              rst,
  // DAC state
  output logic [DATA_BITS-1:0]   dacCode,
  output sdl_pkg::sdl_mode_t     dacMode,
  output logic                   dacUpdate
);
  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int FRAME    = (DATA_BITS == 16) ? `SDL_FRAME_LONG : `SDL_FRAME_SHORT;
  localparam int PAD      = (DATA_BITS == 16) ? `SDL_PAD_BITS_LONG : 0;
  // Mode bits lead after any pad; a 12-bit code leaves two unused tail bits
  localparam int MODE_LSB = FRAME - PAD - `SDL_MODE_BITS;
  localparam int DATA_LSB = MODE_LSB - DATA_BITS;
  localparam int CW       = $clog2(FRAME + 1);
  localparam logic [DATA_BITS-1:0] RESET_CODE = MIDSCALE ? {1'b1, {(DATA_BITS-1){1'b0}}} : '0;

  // Only three widths have a frame layout
  if (DATA_BITS != 12 && DATA_BITS != 14 && DATA_BITS != 16) begin : gBadWidth
    $error("DATA_BITS must be 12, 14 or 16");
  end

  // ----------------------------------------
  // Shifting
  // ----------------------------------------
  logic [FRAME-1:0] shift_q;
  logic [CW-1:0]    count_q;
  logic             armed_q;
  logic [FRAME-1:0] frame;
  logic             lastEdge;

  // Newest bit enters at the bottom, so the first bit ends on top
  assign frame    = {shift_q[FRAME-2:0], link.din};
  assign lastEdge = armed_q && (count_q == CW'(FRAME - 1));

  // Select high clears the frame asynchronously, so an early rise kills it
  always_ff @(negedge link.sclk or posedge rst or posedge link.syncN) begin
    if (rst || link.syncN) begin
      shift_q <= '0;
    end else if (armed_q) begin
      shift_q <= frame;
    end
  end

  always_ff @(negedge link.sclk or posedge rst or posedge link.syncN) begin
    if (rst || link.syncN) begin
      count_q <= '0;
    end else if (lastEdge) begin
      count_q <= '0;
    end else if (armed_q) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Reset leaves the shifter disarmed: bits count only after a select rise
  always_ff @(negedge link.sclk or posedge rst or posedge link.syncN) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (link.syncN) begin
      armed_q <= 1'b1;
    end else if (lastEdge) begin
      armed_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Apply
  // ----------------------------------------
  logic apply;
  assign apply = lastEdge && !link.syncN;

  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      dacCode <= RESET_CODE;
    end else if (apply) begin
      dacCode <= frame[DATA_LSB +: DATA_BITS];
    end
  end

  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      dacMode <= sdl_pkg::sdl_mode_t'(`SDL_RESET_MODE);
    end else if (apply) begin
      dacMode <= sdl_pkg::sdl_mode_t'(frame[MODE_LSB +: `SDL_MODE_BITS]);
    end
  end

  // Link clock stops between frames, so the flag stays up until the next fall
  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      dacUpdate <= 1'b0;
    end else begin
      dacUpdate <= apply;
    end
  end
endmodule

// [verilog/sdl_host.sv]
// Purpose: Host side: sends one frame per request over the three-wire link.
// Assumes: Request word and strobe are in the clock domain.
// Notes:   Link clock is divided from clock; select is parked low when idle.
`include "sdl_defs.svh"

module sdl_host #(
  parameter int DATA_BITS = 16,
  parameter int HALF_CYC  = `SDL_SCLK_HALF_CYC,
  parameter int GAP_CYC   = `SDL_SYNC_HIGH_CYC
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Request
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic [DATA_BITS-1:0] reqCode,
  input  sdl_pkg::sdl_mode_t     reqMode,
  // Link
  sdl_link_if.host               link
);
  localparam int FRAME    = (DATA_BITS == 16) ? `SDL_FRAME_LONG : `SDL_FRAME_SHORT;
  localparam int PAD      = (DATA_BITS == 16) ? `SDL_PAD_BITS_LONG : 0;
  localparam int MODE_LSB = FRAME - PAD - `SDL_MODE_BITS;
  localparam int DATA_LSB = MODE_LSB - DATA_BITS;
  localparam int CW       = $clog2(FRAME + 1);

  // Timer is eight bits wide
  if (HALF_CYC < `SDL_SCLK_HALF_CYC || GAP_CYC < `SDL_SYNC_HIGH_CYC || GAP_CYC > 255 || HALF_CYC > 255) begin : gBadTiming
    $error("Timing parameters out of range");
  end
  if (DATA_BITS != 12 && DATA_BITS != 14 && DATA_BITS != 16) begin : gBadWidth
    $error("DATA_BITS must be 12, 14 or 16");
  end

  // Pad and unused tail bits go out as zeros
  logic [FRAME-1:0] load;
  always_comb begin
    load = '0;
    load[MODE_LSB +: `SDL_MODE_BITS] = reqMode;
    load[DATA_LSB +: DATA_BITS]      = reqCode;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {SDL_IDLE = 2'h0, SDL_GAP = 2'h1, SDL_SHIFT = 2'h3, SDL_DONE = 2'h2} sdl_hstate_t;
  sdl_hstate_t      state_q;
  logic [7:0]       timer_q;
  logic [CW-1:0]    bits_q;
  logic [FRAME-1:0] word_q;
  logic             sclk_q;
  logic             syncN_q;

  assign reqReady   = state_q == SDL_IDLE;
  assign link.syncN = syncN_q;
  assign link.sclk  = sclk_q;
  assign link.din   = word_q[FRAME-1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SDL_IDLE;
      timer_q <= 8'h00;
      bits_q  <= '0;
      word_q  <= '0;
      sclk_q  <= 1'b1;
      syncN_q <= 1'b0;
    end else begin
      unique case (state_q)
        SDL_IDLE: begin
          if (reqValid) begin
            word_q  <= load;
            syncN_q <= 1'b1;
            timer_q <= 8'(GAP_CYC - 1);
            state_q <= SDL_GAP;
          end
        end
        SDL_GAP: begin
          if (timer_q == 8'h00) begin
            syncN_q <= 1'b0;
            timer_q <= 8'(HALF_CYC - 1);
            bits_q  <= '0;
            state_q <= SDL_SHIFT;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        SDL_SHIFT: begin
          if (timer_q == 8'h00) begin
            timer_q <= 8'(HALF_CYC - 1);
            sclk_q  <= ~sclk_q;
            if (!sclk_q) begin
              word_q <= {word_q[FRAME-2:0], 1'b0};
              if (bits_q == CW'(FRAME - 1))
                state_q <= SDL_DONE;
              bits_q <= bits_q + 1'b1;
            end
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        SDL_DONE: begin
          if (timer_q == 8'h00) begin
            state_q <= SDL_IDLE;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// [tb/sdl_link_checker.sv]
// Purpose: Wire checks on the host-to-device load link.
// Assumes: 24-bit frames, host divider at its defaults.
// Notes:   Sees only the link wires, the host clock and reset.
module sdl_link_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic syncN,
  input wire logic sclk,
  input wire logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] fallCnt_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Falling edges seen in the current frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) fallCnt_q <= 5'h00;
    else if (syncN) fallCnt_q <= 5'h00;
    else if ($fell(sclk)) fallCnt_q <= fallCnt_q + 5'h01;
  end
  AST_SYNC_GAP: assert property ($rose(syncN) |-> syncN [*4])
    else $error("select high too short");
  AST_SCLK_IDLE: assert property (syncN |-> sclk)
    else $error("link clock low while deselected");
  AST_FIRST_FALL: assert property ($fell(syncN) |-> ##2 $fell(sclk))
    else $error("first link clock fall misplaced");
  AST_LOW_HALF: assert property ($fell(sclk) |=> !sclk)
    else $error("link clock low phase too short");
  AST_HIGH_HALF: assert property ($rose(sclk) && !syncN |=> sclk)
    else $error("link clock high phase too short");
  AST_DIN_HOLD: assert property ($fell(sclk) |-> $stable(din))
    else $error("data moved at sampling edge");
  AST_FRAME_LEN: assert property ($rose(syncN) |-> fallCnt_q inside {5'h00, 5'h18})
    else $error("frame length not 24");
  AST_NO_EXTRA: assert property (fallCnt_q == 5'h18 |-> !$fell(sclk))
    else $error("edge after frame end");
endmodule

// [tb/serial_dac_load_interface_tb_top.sv]
// Purpose: Bench joining host and device, plus a hand-driven device.
// Assumes: 24-bit frames, 100 MHz clock.
// Notes:   The second device sees one broken 23-bit frame between two full frames from the bench.
module serial_dac_load_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               reqValid = 1'b0;
  logic               reqReady;
  logic [15:0]        reqCode = 16'h0000;
  sdl_pkg::sdl_mode_t reqMode = sdl_pkg::SDL_MODE_NORMAL;
  logic [15:0]        dacCode, code2;
  sdl_pkg::sdl_mode_t dacMode, mode2;
  logic               dacUpdate, update2;
  int                 err_count = 0, samples_checked = 0, cycles = 0;
  sdl_link_if link ();
  sdl_link_if link2 ();
  sdl_host i_sdl_host (.clock(clock), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .reqCode(reqCode), .reqMode(reqMode), .link(link.host));
  sdl_device i_sdl_device (.link(link.dev), .rst(rst), .dacCode(dacCode), .dacMode(dacMode),
    .dacUpdate(dacUpdate));
  sdl_device i_sdl_device_2 (.link(link2.dev), .rst(rst), .dacCode(code2), .dacMode(mode2),
    .dacUpdate(update2));
  sdl_link_checker i_sdl_link_checker (.clock(clock), .rst(rst), .syncN(link.syncN), .sclk(link.sclk),
    .din(link.din));
  initial forever #5 clock = ~clock;
  // Seven frames need about 1000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk_code(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_mode(string what, sdl_pkg::sdl_mode_t exp, sdl_pkg::sdl_mode_t got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(sdl_pkg::sdl_mode_t m, logic [15:0] c);
    int n = 0;
    @(posedge clock);
    reqMode <= m;
    reqCode <= c;
    reqValid <= 1'b1;
    @(posedge clock);
    reqValid <= 1'b0;
    // Sample off the edge so the ready flag has settled
    do begin
      @(posedge clock);
      #1 n++;
    end while (reqReady !== 1'b1 && n < 500);
    chk_flag("reqReady", 1'b1, reqReady);
  endtask
  // Hand-driven frame of nb bits; select rises afterwards
  task automatic frame2(logic [23:0] w, int nb);
    @(posedge clock);
    link2.syncN <= 1'b1;
    repeat (4) @(posedge clock);
    link2.syncN <= 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      repeat (2) @(posedge clock);
      link2.din <= w[i];
      repeat (2) @(posedge clock);
      link2.sclk <= 1'b0;
      repeat (2) @(posedge clock);
      link2.sclk <= 1'b1;
    end
    repeat (2) @(posedge clock);
    link2.syncN <= 1'b1;
    link2.din <= ~link2.din;
    repeat (2) @(posedge clock);
  endtask
  task automatic test_reset();
    chk_code("dacCode", 16'h0000, dacCode);
    chk_mode("dacMode", sdl_pkg::SDL_MODE_NORMAL, dacMode);
    chk_code("code2", 16'h0000, code2);
    chk_mode("mode2", sdl_pkg::SDL_MODE_NORMAL, mode2);
    chk_flag("dacUpdate", 1'b0, dacUpdate);
    chk_flag("update2", 1'b0, update2);
    $display("test_reset done");
  endtask
  task automatic test_modes();
    logic [15:0] codes [4] = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'h1234};
    for (int m = 0; m < 4; m++) begin
      send(sdl_pkg::sdl_mode_t'(m), codes[m]);
      chk_code("dacCode", codes[m], dacCode);
      chk_mode("dacMode", sdl_pkg::sdl_mode_t'(m), dacMode);
      chk_flag("dacUpdate", 1'b1, dacUpdate);
    end
    $display("test_modes done");
  endtask
  task automatic test_abort();
    frame2({6'h2A, 2'h1, 16'hBEEF}, 24);
    chk_code("code2", 16'hBEEF, code2);
    chk_mode("mode2", sdl_pkg::SDL_MODE_PD_1K, mode2);
    chk_flag("update2", 1'b1, update2);
    frame2({6'h00, 2'h3, 16'h1357}, 23);
    chk_code("code2", 16'hBEEF, code2);
    chk_mode("mode2", sdl_pkg::SDL_MODE_PD_1K, mode2);
    chk_flag("update2", 1'b0, update2);
    frame2({6'h3F, 2'h2, 16'h2468}, 24);
    chk_code("code2", 16'h2468, code2);
    chk_mode("mode2", sdl_pkg::SDL_MODE_PD_100K, mode2);
    chk_flag("update2", 1'b1, update2);
    $display("test_abort done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    link2.syncN = 1'b0;
    link2.sclk = 1'b1;
    link2.din = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_modes();
    test_abort();
    finish_test();
  end
endmodule
